// file: verilog/ipx_expander.sv
/*
  Two-wire serial eight-bit open-drain port expander: slave address match,
  quasi-bidirectional port latches, read snapshot and change interrupt.
  Assumes SCL and SDA arrive asynchronously and are resolved by the bench
  from the output enables; all pins are open drain.
*/
// Behaviour
// [R1] Variant 0 answers only addresses whose top four bits are 0100.
// [R2] Variant 1 answers only addresses whose top four bits are 0111.
// [R3] Low three address bits come from the three address-select pins.
// [R4] After reset all eight port latches hold one.
// [R5] Port pin drives low when its latch is zero, else released.
// [R6] Interrupt pin is open drain, low while pending.
// [R7] Interrupt asserts within 4 us of an input change.
// [R8] Interrupt releases within 4 us of the clearing acknowledge.
// [R9] Written port levels appear on pins within 4 us.
// [R10] Any edge on a pin whose latch is one raises interrupt.
// [R11] Read returns actual pin levels and clears the interrupt.
// [R12] Every written data byte updates all eight latches.
// [R13] Pin levels are sampled during the acknowledge before each read byte.
// [R14] Pin levels pass synchronisers before edge detection.
`timescale 1ns/1ps
module ipx_expander #(
  parameter bit VARIANT = 1'b0
) (
  input  wire logic                        ref_clk,
  input  wire logic                        nrst,
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output logic                             sda_oe,
  output logic                             sda_out,
  input  wire logic                        addr_sel_bit0_pin,
  input  wire logic                        addr_sel_bit1_pin,
  input  wire logic                        addr_sel_bit2_pin,
  input  wire logic [ipx_pkg::PORT_W-1:0]  io_port_pins_in,
  output logic      [ipx_pkg::PORT_W-1:0]  io_port_pins_out,
  output logic      [ipx_pkg::PORT_W-1:0]  io_port_pins_oe,
  output logic                             irq_n_out,
  output logic                             irq_n_oe
);
  localparam int W = ipx_pkg::PORT_W;

  logic       [1:0]   bus_s;
  logic       [W-1:0] pins_s;
  logic       [2:0]   asel_s;
  logic               scl_s;
  logic               sda_s;
  logic               scl_d_ff;
  logic               sda_d_ff;
  ipx_pkg::ipx_state_e st_ff;
  logic       [3:0]   bitc_ff;
  logic       [7:0]   shift_ff;
  logic       [W-1:0] latch_ff;
  logic       [W-1:0] pins_d_ff;
  logic       [W-1:0] snap_ff;
  logic               pend_ff;
  logic               ack_ff;
  logic               rd_ff;
  logic               sda_oe_ff;

  ipx_sync #(.W(2), .RST(2'h3)) u_bus_sync (
    .clk  (ref_clk),
    .nrst (nrst),
    .d    ({scl_in, sda_in}),
    .q    (bus_s)
  );
  ipx_sync #(.W(W), .RST(ipx_pkg::PORT_RST)) u_pin_sync ( // [R14]
    .clk  (ref_clk),
    .nrst (nrst),
    .d    (io_port_pins_in),
    .q    (pins_s)
  );
  ipx_sync #(.W(3), .RST(3'h0)) u_asel_sync (
    .clk  (ref_clk),
    .nrst (nrst),
    .d    ({addr_sel_bit2_pin, addr_sel_bit1_pin, addr_sel_bit0_pin}),
    .q    (asel_s)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  wire        scl_rise   = scl_s & ~scl_d_ff;
  wire        scl_fall   = ~scl_s & scl_d_ff;
  wire        start_cond = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire        stop_cond  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  wire [3:0]  addr_hi    = VARIANT ? ipx_pkg::ADDR_HI_VAR1 : ipx_pkg::ADDR_HI_VAR0; // [R1] [R2]
  wire [6:0]  my_addr    = {addr_hi, asel_s}; // [R3]
  wire [7:0]  rx_byte    = {shift_ff[6:0], sda_s};
  wire        byte_done  = scl_rise & (bitc_ff == ipx_pkg::BIT_LAST);
  wire        addr_hit   = rx_byte[7:1] == my_addr;
  wire        in_ack     = bitc_ff == ipx_pkg::BIT_ACK;
  // Any edge on a pin used as an input; an output-low pin never toggles itself.
  wire        pin_edge   = |((pins_s ^ pins_d_ff) & latch_ff); // [R10]
  wire        ack_fall   = scl_fall & in_ack;
  wire        rd_clear   = scl_rise & in_ack & rd_ff; // [R11]
  wire        wr_clear   = ack_fall & (st_ff == ipx_pkg::IPX_WR);
  wire        nxt_pend   = pin_edge | (pend_ff & ~(rd_clear | wr_clear));
  wire [2:0]  tx_idx     = ipx_pkg::BIT_MSB - bitc_ff[2:0];
  wire        tx_bit     = snap_ff[tx_idx];

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_d_ff  <= 1'b1;
      sda_d_ff  <= 1'b1;
      pins_d_ff <= ipx_pkg::PORT_RST;
      pend_ff   <= 1'b0;
      snap_ff   <= ipx_pkg::PORT_RST;
    end
    else
    begin
      scl_d_ff  <= scl_s;
      sda_d_ff  <= sda_s;
      pins_d_ff <= pins_s;
      pend_ff   <= nxt_pend; // [R7] [R8]
      if (scl_rise & in_ack & rd_ff)
      begin
        snap_ff <= pins_s; // [R13] [R11]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff     <= ipx_pkg::IPX_IDLE;
      bitc_ff   <= ipx_pkg::BIT_ZERO;
      shift_ff  <= 8'h00;
      latch_ff  <= ipx_pkg::PORT_RST; // [R4]
      ack_ff    <= 1'b0;
      rd_ff     <= 1'b0;
      sda_oe_ff <= 1'b0;
    end
    else if (start_cond)
    begin
      st_ff     <= ipx_pkg::IPX_ADDR;
      bitc_ff   <= ipx_pkg::BIT_ZERO;
      rd_ff     <= 1'b0;
      ack_ff    <= 1'b0;
      sda_oe_ff <= 1'b0;
    end
    else if (stop_cond)
    begin
      st_ff     <= ipx_pkg::IPX_IDLE;
      rd_ff     <= 1'b0;
      sda_oe_ff <= 1'b0;
    end
    else
    begin
      if (scl_rise)
      begin
        shift_ff <= rx_byte;
        bitc_ff  <= in_ack ? ipx_pkg::BIT_ZERO : bitc_ff + 4'h1;
      end
      if (byte_done)
      begin
        case (st_ff)
          ipx_pkg::IPX_ADDR:
          begin
            ack_ff <= addr_hit;
            rd_ff  <= addr_hit & rx_byte[0];
            st_ff  <= addr_hit ? (rx_byte[0] ? ipx_pkg::IPX_RD : ipx_pkg::IPX_WR)
                               : ipx_pkg::IPX_IGNORE;
          end
          ipx_pkg::IPX_WR:
          begin
            latch_ff <= rx_byte; // [R12] [R9]
            ack_ff   <= 1'b1;
          end
          ipx_pkg::IPX_RD:
          begin
            ack_ff <= 1'b0;
            // Master NACK arrives in the ack slot; release and wait for stop.
          end
          default:
          begin
            ack_ff <= 1'b0;
          end
        endcase
      end
      if (st_ff == ipx_pkg::IPX_RD && scl_rise && in_ack && sda_s)
      begin
        st_ff <= ipx_pkg::IPX_IGNORE;
        rd_ff <= 1'b0;
      end
      // SDA changes only while SCL is low, so data never mimics start or stop.
      if (scl_fall)
      begin
        // The acknowledge slot opens at the fall after the eighth rise, count at ack.
        if (in_ack && ack_ff)
        begin
          sda_oe_ff <= 1'b1;
          ack_ff    <= 1'b0;
        end
        else if (st_ff == ipx_pkg::IPX_RD && !in_ack)
        begin
          sda_oe_ff <= ~tx_bit;
        end
        else
        begin
          sda_oe_ff <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      io_port_pins_oe  <= {W{1'b0}};
      io_port_pins_out <= {W{1'b0}};
      irq_n_oe         <= 1'b0;
      irq_n_out        <= 1'b0;
      sda_oe           <= 1'b0;
      sda_out          <= 1'b0;
    end
    else
    begin
      io_port_pins_oe  <= ~latch_ff; // [R5]
      io_port_pins_out <= {W{1'b0}};
      irq_n_oe         <= pend_ff; // [R6]
      irq_n_out        <= 1'b0;
      sda_oe           <= sda_oe_ff;
      sda_out          <= 1'b0;
    end
  end
endmodule // ipx_expander

// file: verilog/ipx_pkg.sv
/*
  Shared constants of the port expander: address prefixes of the two variants,
  port reset value, latency limits and serial-state enumeration.
  Assumes a 10 MHz system clock named ref_clk.
*/
package ipx_pkg;
  localparam int          PORT_W          = 8;
  localparam logic [3:0]  ADDR_HI_VAR0    = 4'h4;
  localparam logic [3:0]  ADDR_HI_VAR1    = 4'h7;
  localparam logic [7:0]  PORT_RST        = 8'hff;
  localparam int          CLK_HZ          = 10000000;
  localparam int          IRQ_ASSERT_US   = 4;
  localparam int          IRQ_CLEAR_US    = 4;
  localparam int          PORT_UPDATE_US  = 4;
  localparam int          IRQ_ASSERT_CYC  = IRQ_ASSERT_US * (CLK_HZ / 1000000);
  localparam int          IRQ_CLEAR_CYC   = IRQ_CLEAR_US * (CLK_HZ / 1000000);
  localparam int          PORT_UPDATE_CYC = PORT_UPDATE_US * (CLK_HZ / 1000000);
  localparam logic [3:0]  BIT_LAST        = 4'h7;
  localparam logic [3:0]  BIT_ACK         = 4'h8;
  localparam logic [3:0]  BIT_ZERO        = 4'h0;
  localparam logic [2:0]  BIT_MSB         = 3'h7;

  typedef enum logic [2:0] {
    IPX_IDLE,
    IPX_ADDR,
    IPX_WR,
    IPX_RD,
    IPX_IGNORE
  } ipx_state_e;
endpackage

// file: verilog/ipx_sync.sv
/*
  Three-stage synchroniser with agreement filter for a bus of pins.
  Assumes inputs are asynchronous to clk; output changes only once
  stages two and three agree.
*/
`timescale 1ns/1ps
module ipx_sync #(
  parameter int W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] nxt_q;

  assign nxt_q = (s2_ff & s3_ff) | (q & (s2_ff | s3_ff));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_ff <= RST;
      s2_ff <= RST;
      s3_ff <= RST;
      q     <= RST;
    end
    else
    begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q     <= nxt_q;
    end
  end
endmodule // ipx_sync

// file: verif/ipx_master.sv
/* Two-wire bus master model, 100 kHz SCL made from ref_clk.
   Assumes an open-drain SDA with pull-up; device sinks arrive on dev_oe. */
`timescale 1ns/1ps
module ipx_master (
  input  wire logic       ref_clk,
  input  wire logic [1:0] dev_oe,
  output logic            scl,
  output logic            sda
);
  logic drv = 1'b1;
  initial scl = 1'b1;
  // The pull-up wins unless a party sinks the line, so released means one.
  assign sda = drv & ~|dev_oe;
  // Data moves a quarter bit before SCL so it never changes under SCL high.
  task automatic step(input logic c, input logic d);
    drv = d;
    repeat (25) @(posedge ref_clk);
    #1;
    scl = c;
    repeat (25) @(posedge ref_clk);
    #1;
  endtask
  task automatic start;
    step(1'b1, 1'b0);
  endtask
  task automatic stop;
    step(1'b0, drv);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic xfer(input logic [7:0] d, input logic am, output logic [7:0] r,
                      output logic ak);
    logic [8:0] v;
    logic [8:0] s;
    v = {d, am};
    for (int i = 8; i >= 0; i--)
    begin
      step(1'b0, drv);
      step(1'b1, v[i]);
      s[i] = sda;
    end
    r = s[8:1];
    ak = s[0];
  endtask
endmodule // ipx_master

// file: verif/ipx_expander_chk.sv
/* Port expander checker on the top-level ports.
   Assumes one ref_clk domain and nrst active low. */
`timescale 1ns/1ps
module ipx_expander_chk (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       scl_in,
  input wire logic       sda_oe,
  input wire logic       sda_out,
  input wire logic [7:0] io_port_pins_in,
  input wire logic [7:0] io_port_pins_out,
  input wire logic [7:0] io_port_pins_oe,
  input wire logic       irq_n_out,
  input wire logic       irq_n_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_in_edge;
    $stable(io_port_pins_oe) ##0
      ((io_port_pins_in ^ $past(io_port_pins_in)) & ~io_port_pins_oe) != 8'h00;
  endsequence
  chk_rst_idle: assert property ($rose(nrst) |-> io_port_pins_oe == 8'h00 && !irq_n_oe)
    else $error("not idle after reset");
  chk_pin_drive: assert property (io_port_pins_out == 8'h00)
    else $error("port pin driven high");
  chk_irq_drive: assert property (irq_n_out == 1'b0)
    else $error("interrupt pin driven high");
  chk_sda_drive: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  chk_sda_hold: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed while clock high");
  chk_irq_late: assert property (s_in_edge |-> ##[1:40] irq_n_oe)
    else $error("interrupt late");
  chk_irq_cause: assert property ($rose(irq_n_oe) |-> io_port_pins_in != $past(io_port_pins_in, 10))
    else $error("interrupt without edge");
  chk_irq_sync: assert property ($changed(io_port_pins_in) && !irq_n_oe |=> !irq_n_oe)
    else $error("interrupt bypassed synchroniser");
endmodule // ipx_expander_chk
bind ipx_expander ipx_expander_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .scl_in(scl_in),
  .sda_oe(sda_oe), .sda_out(sda_out), .io_port_pins_in(io_port_pins_in),
  .io_port_pins_out(io_port_pins_out), .io_port_pins_oe(io_port_pins_oe),
  .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

// file: verif/ipx_expander_tb.sv
/* Bench for the port expander: both variants on one bus, driven by a master model.
   Assumes the package, design, master model and checker are compiled first. */
`timescale 1ns/1ps
module ipx_expander_tb;
  logic       ref_clk = 1'b0;
  logic       nrst    = 1'b0;
  logic [7:0] ext_drv = 8'hff;
  logic [2:0] strap   = 3'h5;
  logic [7:0] pins_oe;
  wire  [1:0] dev_oe;
  logic       scl;
  logic       sda;
  logic       irq_oe;
  logic       ack;
  logic [7:0] rd;
  int         err_total   = 0;
  int         comparisons = 0;
  // Port pins have pull-ups, so a pin reads low only while someone sinks it.
  wire  [7:0] pins = ext_drv & ~pins_oe;
  initial forever #50 ref_clk = ~ref_clk;
  ipx_master u_mst (.ref_clk(ref_clk), .dev_oe(dev_oe), .scl(scl), .sda(sda));
  ipx_expander #(.VARIANT(1'b0)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .scl_in(scl),
    .sda_in(sda), .sda_oe(dev_oe[0]), .sda_out(), .addr_sel_bit0_pin(strap[0]),
    .addr_sel_bit1_pin(strap[1]), .addr_sel_bit2_pin(strap[2]), .io_port_pins_in(pins),
    .io_port_pins_out(), .io_port_pins_oe(pins_oe), .irq_n_out(), .irq_n_oe(irq_oe));
  ipx_expander #(.VARIANT(1'b1)) u_dut1 (.ref_clk(ref_clk), .nrst(nrst), .scl_in(scl),
    .sda_in(sda), .sda_oe(dev_oe[1]), .sda_out(), .addr_sel_bit0_pin(strap[0]),
    .addr_sel_bit1_pin(strap[1]), .addr_sel_bit2_pin(strap[2]), .io_port_pins_in(pins),
    .io_port_pins_out(), .io_port_pins_oe(), .irq_n_out(), .irq_n_oe());
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("errors=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Pins change after the address acknowledge, so the snapshot must hold old levels.
  task automatic rd_chk(input logic [7:0] e, input logic [7:0] mid);
    u_mst.start();
    u_mst.xfer(8'h4b, 1'b1, rd, ack);
    ext_drv = mid;
    u_mst.xfer(8'hff, 1'b1, rd, ack);
    u_mst.stop();
    cmp(rd, e);
  endtask
  task automatic t_addr;
    logic [6:0] adr [4] = '{7'h25, 7'h3d, 7'h21, 7'h24};
    for (int i = 0; i < 4; i++)
    begin
      u_mst.start();
      u_mst.xfer({adr[i], 1'b0}, 1'b1, rd, ack);
      u_mst.stop();
      cmp({7'h00, ack}, {7'h00, i > 1});
    end
  endtask
  task automatic t_write;
    u_mst.start();
    u_mst.xfer(8'h4a, 1'b1, rd, ack);
    u_mst.xfer(8'h5a, 1'b1, rd, ack);
    cmp(pins_oe, 8'ha5);
    u_mst.xfer(8'hc3, 1'b1, rd, ack);
    cmp(pins_oe, 8'h3c);
    u_mst.stop();
  endtask
  task automatic t_irq;
    u_mst.start();
    u_mst.xfer(8'h4a, 1'b1, rd, ack);
    u_mst.xfer(8'h0f, 1'b1, rd, ack);
    u_mst.stop();
    rd_chk(8'h0f, 8'hff);
    wt(40);
    cmp({7'h00, irq_oe}, 8'h00);
    ext_drv = 8'hf7;
    wt(40);
    cmp({7'h00, irq_oe}, 8'h01);
    // The closing acknowledge of a read clears as well, so a mid-read edge is not kept.
    rd_chk(8'h07, 8'hff);
    wt(40);
    cmp({7'h00, irq_oe}, 8'h00);
    ext_drv = 8'hfb;
    wt(40);
    cmp({7'h00, irq_oe}, 8'h01);
    rd_chk(8'h0b, 8'hff);
    wt(40);
    cmp({7'h00, irq_oe}, 8'h00);
  endtask
  initial
  begin
    wt(2);
    nrst = 1'b1;
    wt(12);
    cmp(pins_oe, 8'h00);
    t_addr();
    t_write();
    t_irq();
    nrst = 1'b0;
    wt(2);
    cmp(pins_oe, 8'h00);
    nrst = 1'b1;
    wt(12);
    cmp({7'h00, irq_oe}, 8'h00);
    close_out();
  end
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    close_out();
  end
endmodule // ipx_expander_tb
